// file: rtl/wrb_wakeup_ctrl.v
`timescale 1ns/100ps
`include "wrb_map.vh"
// Operation
// - reset pin wakes sleep, deep-sleep and power-down if enabled
// - pin interrupt needs controller and pin enable
// - brownout irq needs four enables to wake
// - brownout reset ends deep modes when enabled
// - watchdog irq wakes with full enable set
// - watchdog reset ends deep modes when running
// - wake timer wakes; nonzero count write starts it
// - serial target irq wakes with external clock
// - wake pin ends deep power-down if enabled
// - reset pin ends deep power-down if enabled
// - timer in deep power-down needs osc kept
// - start on free-running oscillator after power-up
// - four reset sources, start osc, init flash
// - fetch from address zero after release
// - brownout level compare raises irq, status
// - brownout reset enabled, level zero default
module wrb_wakeup_ctrl #(
    parameter NPIN = 8,   // pin interrupt lines
    parameter TW   = 16   // wake timer width
) (
    // clock and power-on reset
    input  wire            mclk,
    input  wire            reset,
    // power mode from the core
    input  wire [2:0]      power_mode,
    // external pins, asynchronous
    input  wire            reset_pin_io_n,
    input  wire            wake_pin_io_n,
    input  wire [NPIN-1:0] pin_irq_in,
    input  wire            serial_irq_in,
    input  wire            serial_ext_clk_ok,
    input  wire            serial_target_mode,
    // brownout comparator flags, one per level, high when supply below level
    input  wire [3:0]      bod_below,
    // watchdog state
    input  wire            wdt_running,
    input  wire            wdt_irq_evt,
    input  wire            wdt_rst_evt,
    input  wire            wdt_int_en,
    input  wire            wdt_rst_en,
    // core interrupt controller enables
    input  wire [NPIN-1:0] core_interrupt_controller_pin_en,
    input  wire [3:0]      core_interrupt_controller_periph_en,
    // start-logic enables
    input  wire [NPIN-1:0] start_logic_pin_enable,
    input  wire [3:0]      start_logic_periph_enable,
    // pin function and deep power-down control
    input  wire            pin_function_enable0,
    input  wire            dpd_wake_pin_en,
    input  wire            dpd_reset_pin_en,
    input  wire            dpd_low_power_osc_en,
    input  wire            dpd_low_power_osc_keep,
    // brownout control
    input  wire            bod_int_en,
    input  wire            bod_rst_en,
    input  wire [1:0]      bod_int_level,
    input  wire [1:0]      bod_rst_level,
    input  wire            bod_rst_level_wr,
    // sleep power configuration: keep powered in deep-sleep and power-down
    input  wire            sleep_bod_on,
    input  wire            sleep_low_power_osc_on,
    // self-wake timer setup
    input  wire            wkt_lp_clk_sel,
    input  wire            wkt_count_wr,
    input  wire [TW-1:0]   wkt_count_val,
    // outputs
    output reg             core_clk_en_ff,
    output reg             wake_req_ff,
    output reg  [6:0]      wake_src_ff,
    output wire            sys_rst,
    output wire            flash_init,
    output reg             fro_on_ff,
    output reg  [31:0]     boot_addr_ff,
    output reg             bod_irq_ff,
    output reg             bod_status_ff,
    output reg  [1:0]      bod_rst_level_ff,
    output reg             wkt_running_ff,
    output reg             wkt_timeout_ff
);
    // synchronised pins and events
    wire [NPIN-1:0] pin_s;
    wire            rstp_s;
    wire            wakep_s;
    wire            ser_s;
    wire [3:0]      bod_s;

    // the active-low reset and wake pins are inverted before the flops so the cleared synchroniser reads as idle,
    // otherwise a false reset-pin press would follow every power-on reset
    wrb_sync2 #(.WIDTH(NPIN + 7)) u_sync (
        .mclk  (mclk),
        .reset (reset),
        .din   ({pin_irq_in, ~reset_pin_io_n, ~wake_pin_io_n, serial_irq_in, bod_below}),
        .dout  ({pin_s, rstp_s, wakep_s, ser_s, bod_s})
    );

    // mode decode
    wire in_sleep = (power_mode == `WRB_MODE_SLEEP);
    wire in_deep  = (power_mode == `WRB_MODE_DEEPSLEEP) | (power_mode == `WRB_MODE_PWRDOWN);
    wire in_dpd   = (power_mode == `WRB_MODE_DEEPPD);
    wire in_low   = (power_mode != `WRB_MODE_RUN);

    // selects one brownout comparator by level
    function lvl_hit;
        input [3:0] below;
        input [1:0] lvl;
        begin
            lvl_hit = below[lvl];
        end
    endfunction

    // brownout compare at selected levels
    wire bod_int_cond = lvl_hit(bod_s, bod_int_level);
    wire bod_rst_cond = lvl_hit(bod_s, bod_rst_level_ff);
    // detector alive: in deep modes only if kept powered
    wire bod_alive    = ~in_deep | sleep_bod_on;
    wire low_power_osc_alive  = ~in_deep | sleep_low_power_osc_on;

    // per-source wake terms
    wire w_rstpin = (in_sleep | in_deep) & rstp_s & pin_function_enable0;
    wire w_pin    = in_deep & |(pin_s & core_interrupt_controller_pin_en & start_logic_pin_enable);
    wire w_bodi   = in_deep & bod_int_cond & bod_int_en & bod_alive &
                    core_interrupt_controller_periph_en[`WRB_SP_BROWNOUT] & start_logic_periph_enable[`WRB_SP_BROWNOUT];
    wire w_wdti   = in_deep & wdt_running & wdt_irq_evt & wdt_int_en & low_power_osc_alive &
                    core_interrupt_controller_periph_en[`WRB_SP_WATCHDOG] & start_logic_periph_enable[`WRB_SP_WATCHDOG];
    wire w_wkt    = in_deep & wkt_timeout_ff & dpd_low_power_osc_en & wkt_lp_clk_sel &
                    core_interrupt_controller_periph_en[`WRB_SP_WAKETIMER] & start_logic_periph_enable[`WRB_SP_WAKETIMER];
    wire w_ser    = in_deep & ser_s & serial_target_mode & serial_ext_clk_ok &
                    core_interrupt_controller_periph_en[`WRB_SP_SERIAL] & start_logic_periph_enable[`WRB_SP_SERIAL];
    wire w_dpd    = in_dpd & ((wakep_s & dpd_wake_pin_en) | (rstp_s & dpd_reset_pin_en) |
                    (wkt_timeout_ff & dpd_low_power_osc_en & dpd_low_power_osc_keep & wkt_lp_clk_sel));

    wire [6:0] wake_vec = {w_rstpin, w_pin, w_bodi, w_wdti, w_wkt, w_ser, w_dpd};
    wire       any_wake = |wake_vec;

    // reset requests to the merger
    wire bod_rst_req = bod_rst_cond & bod_rst_en & bod_alive & ~in_dpd;
    wire wdt_rst_req = wdt_running & wdt_rst_evt & wdt_rst_en & low_power_osc_alive & ~in_dpd;
    wire pin_rst_req = rstp_s & (in_dpd ? dpd_reset_pin_en : 1'b1);

    wrb_reset_comb u_rst (
        .mclk       (mclk),
        .reset      (reset),
        .pin_rst    (pin_rst_req),
        .wdt_rst    (wdt_rst_req),
        .bod_rst    (bod_rst_req),
        .sys_rst    (sys_rst),
        .flash_init (flash_init)
    );

    // timer clock runs when low-power osc serves it in this mode
    wire wkt_clk_ok = wkt_lp_clk_sel & dpd_low_power_osc_en & (~in_dpd | dpd_low_power_osc_keep);

    reg [TW-1:0] wkt_cnt_ff;  // wake timer down counter
    reg [TW-1:0] nxt_wkt_cnt;
    reg          nxt_wkt_run;
    reg          nxt_wkt_to;

    // wake timer next state; a nonzero count write starts it
    always @* begin
        nxt_wkt_cnt = wkt_cnt_ff;
        nxt_wkt_run = wkt_running_ff;
        nxt_wkt_to  = wkt_timeout_ff;
        if (wkt_count_wr) begin
            nxt_wkt_cnt = wkt_count_val;
            nxt_wkt_run = (wkt_count_val != {TW{1'b0}});
            nxt_wkt_to  = 1'b0;
        end else if (wkt_running_ff & wkt_clk_ok) begin
            if (wkt_cnt_ff == {{(TW-1){1'b0}}, 1'b1}) begin
                nxt_wkt_run = 1'b0;
                nxt_wkt_to  = 1'b1;
            end
            nxt_wkt_cnt = wkt_cnt_ff - {{(TW-1){1'b0}}, 1'b1};
        end else if (~in_low & core_clk_en_ff & wake_req_ff) begin
            // time-out served once core runs again
            nxt_wkt_to  = 1'b0;
        end
    end

    // wake timer registers
    always @(posedge mclk or posedge reset) begin
        if (reset) begin
            wkt_cnt_ff     <= {TW{1'b0}};
            wkt_running_ff <= 1'b0;
            wkt_timeout_ff <= 1'b0;
        end else if (sys_rst) begin
            wkt_cnt_ff     <= {TW{1'b0}};
            wkt_running_ff <= 1'b0;
            wkt_timeout_ff <= 1'b0;
        end else begin
            wkt_cnt_ff     <= nxt_wkt_cnt;
            wkt_running_ff <= nxt_wkt_run;
            wkt_timeout_ff <= nxt_wkt_to;
        end
    end

    // brownout level register, status and interrupt
    always @(posedge mclk or posedge reset) begin
        if (reset) begin
            bod_rst_level_ff <= `WRB_BOD_LEVEL_RST;
            bod_status_ff    <= 1'b0;
            bod_irq_ff       <= 1'b0;
        end else begin
            if (bod_rst_level_wr)
                bod_rst_level_ff <= bod_rst_level;
            bod_status_ff <= bod_int_cond & bod_alive;
            bod_irq_ff    <= bod_int_cond & bod_alive & bod_int_en;
        end
    end

    // core clock gating, wake capture, oscillator and boot address
    always @(posedge mclk or posedge reset) begin
        if (reset) begin
            core_clk_en_ff <= 1'b1;
            wake_req_ff    <= 1'b0;
            wake_src_ff    <= 7'h00;
            fro_on_ff      <= 1'b1;
            boot_addr_ff   <= `WRB_BOOT_ADDR;
        end else if (sys_rst) begin
            core_clk_en_ff <= 1'b1;
            wake_req_ff    <= 1'b0;
            wake_src_ff    <= 7'h00;
            fro_on_ff      <= 1'b1;
            boot_addr_ff   <= `WRB_BOOT_ADDR;
        end else begin
            wake_req_ff <= any_wake;
            if (any_wake)
                wake_src_ff <= wake_vec;
            if (any_wake)
                core_clk_en_ff <= 1'b1;
            else if (in_low)
                core_clk_en_ff <= 1'b0;
            else
                core_clk_en_ff <= 1'b1;
            // free-running osc stays on except in power-down and deeper
            fro_on_ff <= any_wake | ~((power_mode == `WRB_MODE_PWRDOWN) | in_dpd);
        end
    end
endmodule

// file: include/wrb_map.vh
`ifndef WRB_MAP_VH
`define WRB_MAP_VH
// power mode encodings
`define WRB_MODE_RUN        3'h0
`define WRB_MODE_SLEEP      3'h1
`define WRB_MODE_DEEPSLEEP  3'h2
`define WRB_MODE_PWRDOWN    3'h3
`define WRB_MODE_DEEPPD     3'h4
// start-logic peripheral enable bit positions
`define WRB_SP_BROWNOUT     0
`define WRB_SP_WATCHDOG     1
`define WRB_SP_WAKETIMER    2
`define WRB_SP_SERIAL       3
`define WRB_SP_WIDTH        4
// boot fetch address after reset release
`define WRB_BOOT_ADDR       32'h00000000
// brownout reset level selected at reset
`define WRB_BOD_LEVEL_RST   2'h0
// reset stretch length in clocks
`define WRB_RST_STRETCH     4'h4
// flash init pulse length in clocks
`define WRB_FLASH_INIT_LEN  4'h8
`endif

// file: rtl/wrb_sync2.v
`timescale 1ns/100ps
// two flip-flop synchroniser for a vector of levels
module wrb_sync2 #(
    parameter WIDTH = 1
) (
    // clock and reset
    input  wire             mclk,
    input  wire             reset,
    // level in and synchronised level out
    input  wire [WIDTH-1:0] din,
    output wire [WIDTH-1:0] dout
);
    reg [WIDTH-1:0] meta_ff;  // first stage, read only by second stage
    reg [WIDTH-1:0] sync_ff;  // second stage

    // two stage capture
    always @(posedge mclk or posedge reset) begin
        if (reset) begin
            meta_ff <= {WIDTH{1'b0}};
            sync_ff <= {WIDTH{1'b0}};
        end else begin
            meta_ff <= din;
            sync_ff <= meta_ff;
        end
    end

    assign dout = sync_ff;
endmodule

// file: rtl/wrb_reset_comb.v
`timescale 1ns/100ps
`include "wrb_map.vh"
// merges reset sources, asserts on the next clock edge (power-on reset at once), releases on a clock edge after a stretch
module wrb_reset_comb (
    // clock and power-on reset
    input  wire       mclk,
    input  wire       reset,
    // synchronised reset requests
    input  wire       pin_rst,
    input  wire       wdt_rst,
    input  wire       bod_rst,
    // merged reset and flash init
    output wire       sys_rst,
    output wire       flash_init
);
    reg  [3:0] hold_ff;     // stretch counter for reset release
    reg  [3:0] flash_ff;    // flash init countdown
    reg  [3:0] nxt_hold;
    reg  [3:0] nxt_flash;
    wire       any_src;

    assign any_src = pin_rst | wdt_rst | bod_rst;

    // next values of the counters
    always @* begin
        nxt_hold  = hold_ff;
        nxt_flash = flash_ff;
        if (any_src) begin
            nxt_hold  = `WRB_RST_STRETCH;
            nxt_flash = `WRB_FLASH_INIT_LEN;
        end else begin
            if (hold_ff != 4'h0)
                nxt_hold = hold_ff - 4'h1;
            if (flash_ff != 4'h0)
                nxt_flash = flash_ff - 4'h1;
        end
    end

    // counters; power-on reset holds both loaded
    always @(posedge mclk or posedge reset) begin
        if (reset) begin
            hold_ff  <= `WRB_RST_STRETCH;
            flash_ff <= `WRB_FLASH_INIT_LEN;
        end else begin
            hold_ff  <= nxt_hold;
            flash_ff <= nxt_flash;
        end
    end

    // release synchronous to mclk, all logic on the same edge
    assign sys_rst    = (hold_ff != 4'h0);
    assign flash_init = (flash_ff != 4'h0);
endmodule

// file: verification/wrb_pin_model.sv
`timescale 1ns/100ps
// external parties: pins with pull-ups and a serial master that supplies the clock
module wrb_pin_model (
    // requests from the bench
    input  wire pull_rst_low,
    input  wire pull_wake_low,
    input  wire give_clk,
    // lines seen by the controller
    output wire reset_pin_io_n,
    output wire wake_pin_io_n,
    output wire serial_ext_clk_ok
);
    // pull-ups hold both pins high whenever nobody presses them
    assign reset_pin_io_n    = !pull_rst_low;
    assign wake_pin_io_n     = !pull_wake_low;
    // the remote master provides the target-mode clock
    assign serial_ext_clk_ok = give_clk;
endmodule

// file: verification/wrb_wakeup_ctrl_monitor.sv
`timescale 1ns/100ps
// port-level checks of the wake-up and reset controller
module wrb_wakeup_ctrl_monitor #(
    parameter NPIN = 8,  // pin interrupt lines
    parameter TW   = 16  // wake timer width
) (
    // clock and reset
    input wire            mclk,
    input wire            reset,
    // mode, pins and enables
    input wire [2:0]      power_mode,
    input wire [NPIN-1:0] pin_irq_in,
    input wire [NPIN-1:0] core_interrupt_controller_pin_en,
    input wire [NPIN-1:0] start_logic_pin_enable,
    input wire            wake_pin_io_n,
    input wire            dpd_wake_pin_en,
    input wire            dpd_low_power_osc_en,
    input wire            dpd_low_power_osc_keep,
    // brownout
    input wire [3:0]      bod_below,
    input wire [1:0]      bod_int_level,
    input wire [1:0]      bod_rst_level,
    input wire            bod_rst_level_wr,
    input wire            sleep_bod_on,
    // wake timer
    input wire            wkt_lp_clk_sel,
    input wire            wkt_count_wr,
    input wire [TW-1:0]   wkt_count_val,
    // outputs watched
    input wire            wake_req_ff,
    input wire [6:0]      wake_src_ff,
    input wire            sys_rst,
    input wire            flash_init,
    input wire [31:0]     boot_addr_ff,
    input wire            bod_status_ff,
    input wire [1:0]      bod_rst_level_ff,
    input wire            wkt_running_ff
);
    default clocking @(posedge mclk); endclocking
    default disable iff (reset);
    // enabled pin event in deep-sleep, outside reset
    sequence s_pin_ok;
        power_mode == 3'h2 && !sys_rst && |(pin_irq_in & core_interrupt_controller_pin_en & start_logic_pin_enable);
    endsequence
    // wake pin pressed in deep power-down with its wake function on
    sequence s_dpd_pin;
        power_mode == 3'h4 && dpd_wake_pin_en && !wake_pin_io_n;
    endsequence
    // supply below the interrupt level with the detector powered
    sequence s_below;
        !sys_rst && sleep_bod_on && power_mode != 3'h4 && bod_below[bod_int_level];
    endsequence
    a_pin_wake_req: assert property (s_pin_ok[*4] |=> wake_req_ff)
        else $error("pin wake request missing");
    a_pin_src_gate: assert property ($rose(wake_src_ff[5]) && $past(power_mode) == 3'h2 |->
        $past(|(core_interrupt_controller_pin_en & start_logic_pin_enable))) else $error("pin wake without enables");
    a_dpd_pin_wake: assert property (s_dpd_pin[*4] |=> wake_req_ff)
        else $error("wake pin ignored in deep power-down");
    a_bod_status_set: assert property (s_below[*4] |=> bod_status_ff)
        else $error("brownout status not raised");
    a_rst_stretch: assert property ($fell(reset) |-> sys_rst && flash_init)
        else $error("reset not stretched past release");
    a_flash_init_cover: assert property (sys_rst |-> flash_init)
        else $error("flash init shorter than reset");
    a_boot_addr_zero: assert property (boot_addr_ff == 32'h00000000)
        else $error("boot address not zero");
    a_bod_level_default: assert property ($fell(reset) |-> bod_rst_level_ff == 2'h0)
        else $error("brownout reset level not zero after reset");
    a_bod_level_load: assert property (bod_rst_level_wr && !sys_rst |=>
        bod_rst_level_ff == $past(bod_rst_level)) else $error("brownout level not loaded");
    a_wkt_start_run: assert property (wkt_count_wr && wkt_count_val != 0 && wkt_lp_clk_sel && dpd_low_power_osc_en &&
        !sys_rst && (power_mode != 3'h4 || dpd_low_power_osc_keep) |=> wkt_running_ff) else $error("timer not started");
    a_wkt_zero_idle: assert property (wkt_count_wr && wkt_count_val == 0 && !wkt_running_ff |=>
        !wkt_running_ff) else $error("zero count started timer");
endmodule

bind wrb_wakeup_ctrl wrb_wakeup_ctrl_monitor #(.NPIN(NPIN), .TW(TW)) u_wrb_wakeup_ctrl_monitor (.*);

// file: verification/wrb_wakeup_ctrl_tb.sv
`timescale 1ns/100ps
// self-checking bench: integer model of the wake decisions against the controller
module wrb_wakeup_ctrl_tb;
    reg         mclk, reset, serial_irq_in, serial_target_mode, wdt_running, wdt_irq_evt, wdt_rst_evt;
    reg         wdt_int_en, wdt_rst_en, pin_function_enable0, dpd_wake_pin_en, dpd_reset_pin_en, dpd_low_power_osc_en;
    reg         dpd_low_power_osc_keep, bod_int_en, bod_rst_en, bod_rst_level_wr, sleep_bod_on, sleep_low_power_osc_on;
    reg         wkt_lp_clk_sel, wkt_count_wr, pull_rst_low, pull_wake_low, give_clk;
    reg  [2:0]  power_mode;
    reg  [7:0]  pin_irq_in, core_interrupt_controller_pin_en, start_logic_pin_enable;
    reg  [3:0]  bod_below, core_interrupt_controller_periph_en, start_logic_periph_enable, e;
    reg  [1:0]  bod_int_level, bod_rst_level;
    reg  [15:0] wkt_count_val;
    wire        reset_pin_io_n, wake_pin_io_n, serial_ext_clk_ok, core_clk_en_ff, wake_req_ff, sys_rst;
    wire        flash_init, fro_on_ff, bod_irq_ff, bod_status_ff, wkt_running_ff, wkt_timeout_ff;
    wire [6:0]  wake_src_ff;
    wire [31:0] boot_addr_ff;
    wire [1:0]  bod_rst_level_ff;
    integer     seed, miscompares, checks_done, c, m, s, n;

    wrb_wakeup_ctrl u_wrb_wakeup_ctrl (.*);
    wrb_pin_model   u_wrb_pin_model (.*);

    // 10 MHz clock
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end

    // wait cycles, then step just past the edge
    task cyc(input integer cnt);
        begin
            repeat (cnt) @(posedge mclk);
            #1;
        end
    endtask

    // compare against the model and tally
    task chk(input [31:0] act, input [31:0] exp);
        begin
            checks_done = checks_done + 1;
            if (act !== exp) begin
                miscompares = miscompares + 1;
                $display("Error at %0t: got %h expected %h", $time, act, exp);
            end
        end
    endtask

    // enable groups from e: controller, start logic, source enable, powered in sleep
    task drv_per;
        begin
            core_interrupt_controller_periph_en = {4{e[0]}};
            start_logic_periph_enable = {4{e[1]}};
            {bod_int_en, wdt_int_en, serial_target_mode} = {3{e[2]}};
            {sleep_bod_on, sleep_low_power_osc_on, wdt_running, give_clk} = {4{e[3]}};
        end
    endtask

    // counts and verdict
    task summarize;
        begin
            $display("checks %0d miscompares %0d", checks_done, miscompares);
            if (miscompares == 0 && checks_done > 0) $display("TEST PASSED");
            else $display("TEST FAILED");
            $finish;
        end
    endtask

    // hang guard, well beyond the few hundred cycles used
    initial begin
        #500000;
        miscompares = miscompares + 1;
        summarize;
    end

    // main sequence
    initial begin
        seed = 32'hf70d;
        miscompares = 0;
        checks_done = 0;
        {power_mode, pin_irq_in, core_interrupt_controller_pin_en, start_logic_pin_enable, bod_below, wkt_count_val} = '0;
        {core_interrupt_controller_periph_en, start_logic_periph_enable, bod_int_level, bod_rst_level, e} = '0;
        {serial_irq_in, serial_target_mode, wdt_running, wdt_irq_evt, wdt_rst_evt, wdt_int_en, wdt_rst_en} = '0;
        {pin_function_enable0, dpd_wake_pin_en, dpd_reset_pin_en, dpd_low_power_osc_en, dpd_low_power_osc_keep} = '0;
        {bod_int_en, bod_rst_en, bod_rst_level_wr, sleep_bod_on, sleep_low_power_osc_on, wkt_lp_clk_sel} = '0;
        {wkt_count_wr, pull_rst_low, pull_wake_low, give_clk} = '0;
        reset = 1'b1;
        cyc(12);
        chk(sys_rst, 1);
        chk(fro_on_ff, 1);
        chk(boot_addr_ff, 0);
        chk(bod_rst_level_ff, 0);
        reset = 1'b0;
        n = 0;
        while (sys_rst === 1'b1 && n < 20) begin
            cyc(1);
            n = n + 1;
        end
        chk(flash_init, 1);
        cyc(10);
        chk({sys_rst, flash_init}, 0);
        // pin wake needs both enables on the same line
        power_mode = 3'h2;
        for (c = 0; c < 4; c = c + 1) begin
            n = {$random(seed)} % 8;
            {core_interrupt_controller_pin_en, start_logic_pin_enable, pin_irq_in} = '0;
            core_interrupt_controller_pin_en[n] = c[0];
            start_logic_pin_enable[n] = c[1];
            pin_irq_in[n] = 1'b1;
            cyc(6);
            chk(wake_req_ff, c == 3);
            if (c == 3) chk({core_clk_en_ff, wake_src_ff[5]}, 3);
            pin_irq_in = 8'h00;
            cyc(6);
            chk(wake_req_ff, 0);
        end
        // brownout, watchdog and serial wakes, each enable group missing in turn, then all groups on
        for (s = 0; s < 3; s = s + 1) begin
            for (m = 0; m < 5; m = m + 1) begin
                e = 4'hF;
                if (m < 4) e[m] = 1'b0;
                drv_per;
                n = $random(seed);
                bod_int_level = n[1:0];
                bod_below = {4{s == 0}};
                wdt_irq_evt = (s == 1);
                serial_irq_in = (s == 2);
                cyc(6);
                chk(wake_req_ff, m == 4);
                if (s == 0 && m == 4) chk(bod_status_ff, 1);
                if (s == 0 && m == 4) chk(bod_irq_ff, 1);
                {bod_below, wdt_irq_evt, serial_irq_in} = '0;
                cyc(6);
            end
        end
        // wake timer: deep-sleep, deep power-down without and with oscillator kept
        wkt_lp_clk_sel = 1'b1;
        dpd_low_power_osc_en = 1'b1;
        for (c = 0; c < 3; c = c + 1) begin
            power_mode = (c == 0) ? 3'h2 : 3'h4;
            dpd_low_power_osc_keep = (c == 2);
            n = 2 + {$random(seed)} % 6;
            wkt_count_val = n[15:0];
            wkt_count_wr = 1'b1;
            cyc(1);
            wkt_count_wr = 1'b0;
            if (c != 1) chk(wkt_running_ff, 1);
            cyc(n + 4);
            chk(wake_req_ff, c != 1);
            chk(wkt_timeout_ff, c != 1);
            power_mode = 3'h0;
            cyc(4);
        end
        wkt_count_val = 16'h0000;
        wkt_count_wr = 1'b1;
        cyc(1);
        wkt_count_wr = 1'b0;
        cyc(2);
        chk(wkt_running_ff, 0);
        // wake pin in deep power-down, function off then on
        power_mode = 3'h4;
        for (c = 0; c < 2; c = c + 1) begin
            dpd_wake_pin_en = c[0];
            pull_wake_low = 1'b1;
            cyc(6);
            chk(wake_req_ff, c);
            pull_wake_low = 1'b0;
            cyc(6);
        end
        // brownout reset level load, then a brownout reset out of deep-sleep
        n = $random(seed);
        bod_rst_level = n[1:0];
        bod_rst_level_wr = 1'b1;
        cyc(1);
        bod_rst_level_wr = 1'b0;
        chk(bod_rst_level_ff, n[1:0]);
        power_mode = 3'h2;
        bod_rst_en = 1'b1;
        bod_below[n[1:0]] = 1'b1;
        cyc(6);
        chk(sys_rst, 1);
        bod_below = 4'h0;
        cyc(12);
        chk(sys_rst, 0);
        // watchdog reset out of deep-sleep
        wdt_rst_en = 1'b1;
        wdt_rst_evt = 1'b1;
        cyc(2);
        chk(sys_rst, 1);
        wdt_rst_evt = 1'b0;
        cyc(8);
        chk(sys_rst, 0);
        // reset pin in deep power-down with its reset function on
        power_mode = 3'h4;
        dpd_reset_pin_en = 1'b1;
        pull_rst_low = 1'b1;
        cyc(6);
        chk(sys_rst, 1);
        pull_rst_low = 1'b0;
        cyc(12);
        chk(sys_rst, 0);
        summarize;
    end
endmodule
